/* File: logic/sdram_mode_pkg.sv */
// Shared constants and types for the SDRAM mode register and burst logic
// Overview of operation
// - Loaded mode held until next load
// - Bits 0-2 length, 3 type, 4-6 latency
// - Bits 7-8 operating mode, bit 9 write burst
// - Burst length caps columns per access command
// - Lengths 1,2,4,8 both types; full page sequential
// - Full page runs until burst terminate
// - Burst stays inside aligned block, wrapping around
// - Upper column bits pick block, lower start
// - Full page wraps within the open page
// - Order set by length, type and start
// - Length one: addressed column only, type ignored
// - Read latency two or three clocks
// - Drive from edge n+m-1, valid by n+m
// - Write burst bit set makes writes single
package sdram_mode_pkg;

  localparam int ADDR_W = 13;
  localparam int COL_W_DEFAULT = 10;

  // Command codes as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LOAD = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_TERM = 4'h6;
  localparam logic [1:0] LOAD_BANK = 2'h0;

  localparam logic [2:0] BL_CODE_1 = 3'h0;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_FULL = 3'h7;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [2:0] CL_CODE_3 = 3'h3;

  // Stands in for the unknown power-up content: length 1, latency 2
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0020;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank;
    logic [ADDR_W-1:0] addr;
  } cmd_bus_t;

  // Packed from bit 12 down to bit 0 of the captured address
  typedef struct packed {
    logic undefined_bit;
    logic [1:0] reserved;
    logic write_burst_mode_bit;
    logic [1:0] op_mode;
    logic [2:0] read_latency_field;
    logic burst_type_bit;
    logic [2:0] burst_length_field;
  } mode_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BURST = 2'b10
  } burst_state_t;

  // Log2 of the block size; reserved codes fall back to one column
  function automatic logic [1:0] span_of(input logic [2:0] code);
    span_of = code[2] ? 2'h0 : code[1:0];
  endfunction

  function automatic logic is_full_page(input logic [2:0] code);
    is_full_page = (code == BL_CODE_FULL);
  endfunction

endpackage

/* File: logic/burst_column_gen.sv */
// Column address of one beat inside an aligned block or open page
`timescale 1ns/1ps
module burst_column_gen #(
  parameter int COL_W = 10
) (
  // Burst description
  input wire logic [COL_W-1:0] start_col,
  input wire logic [COL_W-1:0] beat_idx,
  input wire logic [1:0] span_log2,
  input wire logic full_page,
  input wire logic interleave,
  // Resulting column
  output logic [COL_W-1:0] col
);

  if (COL_W < 4 || COL_W > 12) begin : g_bad_col_w
    $error("burst_column_gen: COL_W must lie in 4..12");
  end

  logic [3:0] small_mask;
  logic [COL_W-1:0] mask;
  logic [COL_W-1:0] offset;

  always_comb begin
    small_mask = (4'h1 << span_log2) - 4'h1;
    // Full page uses every column bit, so wrap falls at the page end
    mask = full_page ? {COL_W{1'b1}} : {{(COL_W-4){1'b0}}, small_mask};
    offset = interleave ? (start_col ^ beat_idx) : (start_col + beat_idx);
    // Block bits kept from the start column, offset wraps inside it
    col = (start_col & ~mask) | (offset & mask);
  end

endmodule // burst_column_gen

/* File: logic/sdram_mode_burst.sv */
// Mode register, burst sequencer and read latency timing of the SDRAM
`timescale 1ns/1ps
module sdram_mode_burst #(
  parameter int COL_W = sdram_mode_pkg::COL_W_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command pins, registered on the rising clock
  input sdram_mode_pkg::cmd_bus_t cmd,
  // Programmed configuration
  output sdram_mode_pkg::mode_cfg_t mode_cfg,
  // Column access stream, one beat per cycle
  output logic access_valid,
  output logic access_write,
  output logic [COL_W-1:0] access_col,
  // Read data lines
  output logic dq_oe,
  output logic [COL_W-1:0] read_col
);

  if (COL_W < 4 || COL_W > 12) begin : g_bad_col_w
    $error("sdram_mode_burst: COL_W must lie in 4..12");
  end

  // Command decode
  logic [3:0] cmd_code;
  logic is_load;
  logic is_read;
  logic is_write;
  logic is_term;
  logic is_any;

  always_comb begin
    cmd_code = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
    // Bit 12 is stored but never steers anything
    is_load = (cmd_code == sdram_mode_pkg::CMD_LOAD) &&
              (cmd.bank == sdram_mode_pkg::LOAD_BANK);
    is_read = (cmd_code == sdram_mode_pkg::CMD_READ);
    is_write = (cmd_code == sdram_mode_pkg::CMD_WRITE);
    is_term = (cmd_code == sdram_mode_pkg::CMD_TERM);
    is_any = is_load || is_read || is_write || is_term;
  end

  // Mode register
  sdram_mode_pkg::mode_cfg_t next_mode_cfg;

  always_comb begin
    next_mode_cfg = mode_cfg;
    if (is_load) begin
      // Bank state is not checked: loading mid-burst is the controller's fault
      next_mode_cfg = sdram_mode_pkg::mode_cfg_t'(cmd.addr);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_cfg <= sdram_mode_pkg::mode_cfg_t'(sdram_mode_pkg::MODE_RESET);
    end else begin
      mode_cfg <= next_mode_cfg;
    end
  end

  // Burst sequencer
  sdram_mode_pkg::burst_state_t state;
  sdram_mode_pkg::burst_state_t next_state;
  logic [COL_W-1:0] start_col;
  logic [COL_W-1:0] next_start_col;
  logic [COL_W-1:0] beat_idx;
  logic [COL_W-1:0] next_beat_idx;
  logic [COL_W-1:0] beat_last;
  logic [COL_W-1:0] next_beat_last;
  logic [1:0] burst_span;
  logic [1:0] next_burst_span;
  logic burst_full;
  logic next_burst_full;
  logic burst_il;
  logic next_burst_il;
  logic burst_wr;
  logic next_burst_wr;
  logic single;
  logic [3:0] span_count;
  logic [COL_W-1:0] beat_col;

  always_comb begin
    next_state = state;
    next_start_col = start_col;
    next_beat_idx = beat_idx;
    next_beat_last = beat_last;
    next_burst_span = burst_span;
    next_burst_full = burst_full;
    next_burst_il = burst_il;
    next_burst_wr = burst_wr;
    single = is_write && mode_cfg.write_burst_mode_bit;
    span_count = 4'h0;
    case (state)
      sdram_mode_pkg::ST_IDLE: begin
        next_state = sdram_mode_pkg::ST_IDLE;
      end
      sdram_mode_pkg::ST_BURST: begin
        next_beat_idx = beat_idx + {{(COL_W-1){1'b0}}, 1'b1};
        // Full page never ends on its own; it keeps wrapping
        if (!burst_full && beat_idx == beat_last) begin
          next_state = sdram_mode_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = sdram_mode_pkg::ST_IDLE;
      end
    endcase
    if (is_term) begin
      next_state = sdram_mode_pkg::ST_IDLE;
    end
    if (is_read || is_write) begin
      // A new read or write cuts any running burst short
      next_state = sdram_mode_pkg::ST_BURST;
      next_start_col = cmd.addr[COL_W-1:0];
      next_beat_idx = '0;
      next_burst_wr = is_write;
      next_burst_full = !single &&
                        sdram_mode_pkg::is_full_page(mode_cfg.burst_length_field);
      next_burst_span = single ? 2'h0 :
                        sdram_mode_pkg::span_of(mode_cfg.burst_length_field);
      // Interleaved full page is unsupported; it runs sequential
      next_burst_il = mode_cfg.burst_type_bit && !next_burst_full;
      span_count = (4'h1 << next_burst_span) - 4'h1;
      next_beat_last = {{(COL_W-4){1'b0}}, span_count};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= sdram_mode_pkg::ST_IDLE;
      start_col <= '0;
      beat_idx <= '0;
      beat_last <= '0;
      burst_span <= 2'h0;
      burst_full <= 1'b0;
      burst_il <= 1'b0;
      burst_wr <= 1'b0;
    end else begin
      state <= next_state;
      start_col <= next_start_col;
      beat_idx <= next_beat_idx;
      beat_last <= next_beat_last;
      burst_span <= next_burst_span;
      burst_full <= next_burst_full;
      burst_il <= next_burst_il;
      burst_wr <= next_burst_wr;
    end
  end

  // Span zero masks every offset bit, so the type bit has no effect
  burst_column_gen #(
    .COL_W(COL_W)
  ) burst_column_gen_i (
    .start_col(start_col),
    .beat_idx(beat_idx),
    .span_log2(burst_span),
    .full_page(burst_full),
    .interleave(burst_il),
    .col(beat_col)
  );

  // Access stream and read latency pipe
  logic beat_live;
  logic launch;
  logic lat3;
  logic pipe_valid;
  logic next_pipe_valid;
  logic [COL_W-1:0] pipe_col;
  logic [COL_W-1:0] next_pipe_col;
  logic next_access_valid;
  logic next_access_write;
  logic [COL_W-1:0] next_access_col;
  logic next_dq_oe;
  logic [COL_W-1:0] next_read_col;

  always_comb begin
    beat_live = (state == sdram_mode_pkg::ST_BURST);
    launch = beat_live && !burst_wr;
    // Reserved latency codes behave as three, the safer of the two
    lat3 = (mode_cfg.read_latency_field != sdram_mode_pkg::CL_CODE_2);
    next_access_valid = beat_live;
    next_access_write = burst_wr;
    next_access_col = beat_col;
    next_pipe_valid = launch;
    next_pipe_col = beat_col;
    // Beat of a read taken at edge n lands on the pins at edge n+m-1
    next_dq_oe = lat3 ? pipe_valid : launch;
    next_read_col = lat3 ? pipe_col : beat_col;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      access_valid <= 1'b0;
      access_write <= 1'b0;
      access_col <= '0;
      pipe_valid <= 1'b0;
      pipe_col <= '0;
      dq_oe <= 1'b0;
      read_col <= '0;
    end else begin
      access_valid <= next_access_valid;
      access_write <= next_access_write;
      access_col <= next_access_col;
      pipe_valid <= next_pipe_valid;
      pipe_col <= next_pipe_col;
      dq_oe <= next_dq_oe;
      read_col <= next_read_col;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic idle_now;
  logic bl1_mode;
  logic bl4_mode;
  logic lat2_mode;
  assign idle_now = (state == sdram_mode_pkg::ST_IDLE) && !pipe_valid && !dq_oe;
  assign bl1_mode = (mode_cfg.burst_length_field == sdram_mode_pkg::BL_CODE_1);
  assign bl4_mode = (mode_cfg.burst_length_field == sdram_mode_pkg::BL_CODE_4);
  assign lat2_mode = (mode_cfg.read_latency_field == sdram_mode_pkg::CL_CODE_2);

  property p_mode_hold;
    !is_load |=> $stable(mode_cfg);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode register changed without a load");

  property p_mode_capture;
    is_load |=> (mode_cfg == sdram_mode_pkg::mode_cfg_t'($past(cmd.addr)));
  endproperty
  a_mode_capture: assert property (p_mode_capture)
    else $error("mode register did not capture address on load");

  property p_block_wrap;
    beat_live && !burst_full |-> ((beat_col >> burst_span) == (start_col >> burst_span));
  endproperty
  a_block_wrap: assert property (p_block_wrap)
    else $error("beat left its aligned block");

  property p_seq_order;
    beat_live && !burst_il && !burst_full && burst_span == 2'h2 |->
      beat_col[1:0] == 2'(start_col[1:0] + beat_idx[1:0]);
  endproperty
  a_seq_order: assert property (p_seq_order)
    else $error("sequential order wrong");

  property p_il_order;
    beat_live && burst_il && burst_span == 2'h3 |->
      beat_col[2:0] == (start_col[2:0] ^ beat_idx[2:0]);
  endproperty
  a_il_order: assert property (p_il_order)
    else $error("interleaved order wrong");

  property p_lat2;
    idle_now && is_read && lat2_mode |-> ##1 !dq_oe ##1 dq_oe && read_col == $past(beat_col);
  endproperty
  a_lat2: assert property (p_lat2)
    else $error("latency two read not on time");

  property p_lat3;
    idle_now && is_read && !lat2_mode |-> ##1 !dq_oe ##1 !dq_oe ##1 dq_oe;
  endproperty
  a_lat3: assert property (p_lat3)
    else $error("latency three read not on time");

  property p_bl4_len;
    is_read && bl4_mode ##1 !is_any [*4] |->
      ##2 (!access_valid && $past(access_valid) && $past(access_valid, 4));
  endproperty
  a_bl4_len: assert property (p_bl4_len)
    else $error("length four burst gave wrong beat count");

  property p_bl1_single;
    is_read && bl1_mode ##1 !is_any |->
      ##2 (!access_valid && $past(access_valid) && $past(access_col) == $past(cmd.addr[COL_W-1:0], 3));
  endproperty
  a_bl1_single: assert property (p_bl1_single)
    else $error("length one burst not single addressed column");

  property p_wbm_single;
    is_write && mode_cfg.write_burst_mode_bit ##1 !is_any |->
      ##2 (!access_valid && $past(access_valid) && $past(access_write));
  endproperty
  a_wbm_single: assert property (p_wbm_single)
    else $error("write burst mode did not give single write");

  property p_full_runs;
    beat_live && burst_full && !is_any |=> beat_live;
  endproperty
  a_full_runs: assert property (p_full_runs)
    else $error("full page burst stopped without terminate");

  c_lat3_read: cover property (idle_now && is_read && !lat2_mode ##3 dq_oe);
  c_full_term: cover property (beat_live && burst_full ##1 is_term);
  c_il_bl8: cover property (beat_live && burst_il && burst_span == 2'h3);
  c_load: cover property (is_load);

endmodule // sdram_mode_burst

/* File: tb/sdram_ctrl_model.sv */
// Controller-side model that puts commands on the SDRAM pins
`timescale 1ns/1ps
module sdram_ctrl_model (
  // Clock
  input wire logic clk,
  // Request from the bench
  input wire logic req,
  input wire logic [3:0] op,
  input wire logic [12:0] addr,
  // Pins toward the device
  output sdram_mode_pkg::cmd_bus_t cmd
);
  logic [12:0] noise = 13'h0;
  logic [12:0] next_noise;

  always_comb begin
    next_noise = noise + 13'h1a5;
  end

  always_ff @(posedge clk) begin
    noise <= next_noise;
  end

  // Deselected pins keep moving so stale values never look valid
  always_comb begin
    if (req) begin
      cmd = {op, 2'h0, addr};
      if (op == sdram_mode_pkg::CMD_LOAD) begin
        cmd.addr[12] = 1'b0;
        cmd.addr[8:7] = 2'h0;
      end
    end else begin
      cmd = {1'b1, noise[2:0], noise[1:0], noise};
    end
  end
endmodule // sdram_ctrl_model

/* File: tb/sdram_mode_burst_bench.sv */
// Self-checking bench for the mode register and burst sequencer
`timescale 1ns/1ps
module sdram_mode_burst_bench;
  logic clk;
  logic rst;
  logic req;
  logic [3:0] op;
  logic [12:0] addr;
  sdram_mode_pkg::cmd_bus_t cmd;
  sdram_mode_pkg::mode_cfg_t mode_cfg;
  logic access_valid;
  logic access_write;
  logic [9:0] access_col;
  logic dq_oe;
  logic [9:0] read_col;
  logic [12:0] mode_exp;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  int errors;
  int n_checks;
  int seed;

  sdram_ctrl_model sdram_ctrl_model_i (.clk(clk), .req(req), .op(op), .addr(addr), .cmd(cmd));

  sdram_mode_burst sdram_mode_burst_i (
    .clk(clk), .rst(rst), .cmd(cmd), .mode_cfg(mode_cfg),
    .access_valid(access_valid), .access_write(access_write), .access_col(access_col),
    .dq_oe(dq_oe), .read_col(read_col)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100000;
    errors++;
    close_out();
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic drive(logic r, logic [3:0] o, logic [12:0] a);
    @(negedge clk);
    req = r;
    op = o;
    addr = a;
  endtask

  // Column of beat k; interleaved full page runs sequential
  function automatic logic [9:0] exp_col(logic [9:0] s, int k, logic [12:0] md);
    logic [9:0] msk;
    if (md[2:0] == 3'h7) return s + 10'(k);
    msk = 10'((1 << md[1:0]) - 1);
    if (md[3]) return (s & ~msk) | ((s ^ 10'(k)) & msk);
    return (s & ~msk) | ((s + 10'(k)) & msk);
  endfunction

  // Loads only between bursts, so every bank is idle
  task automatic load(logic [2:0] bl, logic bt, logic [2:0] cl, logic wbm);
    mode_exp = {3'h0, wbm, 2'h0, cl, bt, bl};
    drive(1'b1, sdram_mode_pkg::CMD_LOAD, mode_exp);
    drive(1'b0, 4'hf, 13'h0);
    drive(1'b0, 4'hf, 13'h0);
    check("mode_cfg", mode_cfg, mode_exp);
  endtask

  // Full page is cut by a terminate at edge 5, leaving five beats
  task automatic run_burst(logic wr, logic [9:0] s);
    int beats;
    int m;
    int d;
    logic full;
    full = mode_exp[2:0] == 3'h7;
    m = (mode_exp[6:4] == 3'h2) ? 2 : 3;
    // Single-location writes win over every length, full page included
    beats = (wr && mode_exp[9]) ? 1 : full ? 5 : (1 << mode_exp[1:0]);
    drive(1'b1, wr ? sdram_mode_pkg::CMD_WRITE : sdram_mode_pkg::CMD_READ, {3'h0, s});
    for (int j = 0; j <= 12; j++) begin
      drive(full && j == 4, sdram_mode_pkg::CMD_TERM, 13'h0);
      check("access_valid", access_valid, j >= 1 && j <= beats);
      if (j >= 1 && j <= beats) begin
        check("access_write", access_write, wr);
        check("access_col", access_col, exp_col(s, j - 1, mode_exp));
      end
      d = j - m + 1;
      check("dq_oe", dq_oe, !wr && d >= 0 && d < beats);
      if (!wr && d >= 0 && d < beats) begin
        check("read_col", read_col, exp_col(s, d, mode_exp));
      end
    end
    check("mode_cfg", mode_cfg, mode_exp);
  endtask

  initial begin
    seed = 32'h97ebcbb6;
    rst = 1'b1;
    req = 1'b0;
    op = 4'hf;
    addr = 13'h0;
    errors = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check("mode_cfg", mode_cfg, sdram_mode_pkg::MODE_RESET);
    load(3'h7, 1'b1, 3'h2, 1'b0);
    run_burst(1'b0, 10'h3fe);
    load(3'h3, 1'b1, 3'h3, 1'b0);
    run_burst(1'b0, 10'h00d);
    run_burst(1'b1, 10'h02a);
    load(3'h2, 1'b0, 3'h2, 1'b1);
    run_burst(1'b1, 10'h005);
    run_burst(1'b0, 10'h005);
    load(3'h7, 1'b0, 3'h3, 1'b1);
    run_burst(1'b1, 10'h3ff);
    load(3'h0, 1'b1, 3'h3, 1'b0);
    run_burst(1'b0, 10'h1f7);
    // Random mixes of every legal length, type and latency
    repeat (40) begin
      load(codes[$unsigned($random(seed)) % 5], 1'($random(seed)),
           3'h2 + 3'($random(seed) & 1), 1'($random(seed)));
      run_burst(1'($random(seed)), 10'($random(seed)));
      run_burst(1'($random(seed)), 10'($random(seed)));
    end
    close_out();
  end
endmodule // sdram_mode_burst_bench
